// >>> include/tbi_pkg.sv
// Shared constants and types of the serial backplane interface.
// Assumes a single 10 MHz system clock and an APB master with 32-bit data.
package tbi_pkg;

	// Timing of the internally generated link clock
	localparam int CLK_PERIOD_NS = 100;
	localparam int LINK_BIT_NS   = 800;
	localparam int HALF_DIV_CYC  = LINK_BIT_NS / (2 * CLK_PERIOD_NS);

	// Register indices; the byte address is four times the index
	localparam int          NREG          = 10;
	localparam logic [9:0]  IX_TX_MODE    = 10'h043;
	localparam logic [9:0]  IX_TX_CHOFF   = 10'h044;
	localparam logic [9:0]  IX_TX_BITOFF  = 10'h045;
	localparam logic [9:0]  IX_RX_OPT     = 10'h046;
	localparam logic [9:0]  IX_RX_MODE    = 10'h047;
	localparam logic [9:0]  IX_RX_FP      = 10'h048;
	localparam logic [9:0]  IX_RX_CHOFF   = 10'h049;
	localparam logic [9:0]  IX_RX_BITOFF  = 10'h04a;
	localparam logic [9:0]  IX_TX_CLKOPT  = 10'h060;
	localparam logic [9:0]  IX_STATUS     = 10'h061;
	localparam logic [NREG-1:0][9:0] REG_IX = {IX_STATUS, IX_TX_CLKOPT,
		IX_RX_BITOFF, IX_RX_CHOFF, IX_RX_FP, IX_RX_MODE, IX_RX_OPT,
		IX_TX_BITOFF, IX_TX_CHOFF, IX_TX_MODE};

	// Slot numbers of the registers: 0 to 8 are the writable config array, 9 is status
	localparam int R_TXM = 0;
	localparam int R_TCO = 1;
	localparam int R_TBO = 2;
	localparam int R_RXO = 3;
	localparam int R_RXM = 4;
	localparam int R_RFP = 5;
	localparam int R_RCO = 6;
	localparam int R_RBO = 7;
	localparam int R_TCK = 8;
	localparam int R_STS = 9;

	// Reset values and writable masks, slot 8 first
	localparam logic [8:0][7:0] RST_VAL = {8'h00, 8'h00, 8'h00, 8'h00,
		8'h01, 8'h0d, 8'h00, 8'h00, 8'h01};
	localparam logic [8:0][7:0] WR_MASK = {8'h1c, 8'h0f, 8'h7f, 8'h13,
		8'h07, 8'h1f, 8'h0f, 8'h7f, 8'h07};

	// Field positions
	localparam int B_SUBMODE = 0;
	localparam int B_MAP     = 1;
	localparam int B_EDGE    = 3;
	localparam int B_TRI     = 0;
	localparam int B_RCMS    = 1;
	localparam int B_RFE     = 2;
	localparam int B_RDE     = 3;
	localparam int B_GAP     = 4;
	localparam int B_TCMS    = 2;
	localparam int B_TFE     = 3;
	localparam int B_TDE     = 4;
	localparam int B_ALT     = 0;
	localparam int B_FRAME_PULSE_MULTIFRAME    = 1;
	localparam int B_INV     = 4;

	// Frame geometry
	localparam logic [8:0] T1_LAST   = 9'h0c0;
	localparam logic [8:0] E1_LAST   = 9'h0ff;
	localparam logic [4:0] MF_LAST   = 5'h17;
	localparam logic [4:0] SF_LEN    = 5'h0c;

	typedef struct packed {
		logic       f;
		logic       data;
		logic [4:0] chan;
		logic [2:0] bit_no;
	} tbi_slot_s;

	typedef struct packed {
		logic       bev;
		logic       ph;
		logic [9:0] wt;
		logic       run;
		logic [8:0] idx;
		logic [7:0] sd;
		logic [7:0] ss;
	} tbi_dir_s;

	typedef struct packed {
		logic       fbit;
		logic [4:0] chan;
		logic [7:0] data;
		logic [7:0] sig;
	} tbi_word_s;

	typedef struct packed {
		logic [5:0][2:0] sy;
		logic [5:0]      flt;
		tbi_dir_s        tx;
		tbi_dir_s        rx;
		logic            gclk;
		logic [15:0]     div;
		logic [8:0]      gidx;
		logic [4:0]      gfn;
		logic [8:0][7:0] cfg;
		logic            rdy;
		logic            err;
		logic [7:0]      rdata;
		logic            tck_o;
		logic            tfs_o;
		logic            t_oe;
		logic            rck_o;
		logic            rfs_o;
		logic            r_oe;
		logic            rsd_o;
		logic            rsig_o;
		logic            rd_oe;
		tbi_word_s       tw;
		logic            tvalid;
		logic            rtake;
		logic [4:0]      rchan;
	} tbi_state_s;

endpackage

// >>> logic/tbi_backplane.sv
// Serial backplane interface of one T1 channel: transmit capture and
// receive playout, clock master and slave timing, offsets, APB registers.
// Assumes pins arrive asynchronously and the framer side runs on CLK_IN.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps

// Operation
// - Transmit submode 0: device makes clock and pulse; 1: system supplies them
// - Receive submode 0: clock and pulse from line timing; 1: from system
// - Transmit slave map code picks T1, G.802, filler-per-four or continuous
// - Receive slave map code uses the same four mappings
// - Frame starts a programmed number of channels after the pulse
// - A three-bit bit offset shifts the frame start further
// - Signaling bits stay channel aligned with the data bits
// - Transmit double rate: sample on first or second edge per slot select
// - Receive double rate: update on first or second edge per slot select
// - Receive master gap bit stops the receive clock during the F-bit
// - Receive data polarity: 0 updates on falling, 1 on rising edge
// - Receive pulse polarity: 0 uses falling, 1 rising edge
// - Receive clock runs at data rate; the double rate bit leaves it unchanged
// - Receive float bit puts data and signaling outputs in high impedance
// - Receive pulse invert: 0 active high, 1 active low
// - SF master pulse: each, every second, superframe first, alternate superframe first
// - Other formats: every F-bit or multiframe first F-bit; alternate ignored
// - Transmit data polarity: 0 samples on falling, 1 on rising edge
// - Transmit clock runs at data rate; the double rate bit leaves it unchanged
module tbi_backplane #(
	parameter logic [15:0] HALF_DIV = 16'(tbi_pkg::HALF_DIV_CYC)
) (
	input  wire logic              CLK_IN,
	input  wire logic              SYS_RST_IN,
	input  wire logic              PSEL_IN,
	input  wire logic              PENABLE_IN,
	input  wire logic              PWRITE_IN,
	input  wire logic [11:0]       PADDR_IN,
	input  wire logic [31:0]       PWDATA_IN,
	output logic      [31:0]       PRDATA_OUT,
	output logic                   PREADY_OUT,
	output logic                   PSLVERR_OUT,
	input  wire logic              SF_FORMAT_IN,
	input  wire logic              TX_SYS_CLOCK_IN,
	output logic                   TX_SYS_CLOCK_OUT,
	output logic                   TX_SYS_CLOCK_OE_OUT,
	input  wire logic              TX_SYS_FRAME_PULSE_IN,
	output logic                   TX_SYS_FRAME_PULSE_OUT,
	output logic                   TX_SYS_FRAME_PULSE_OE_OUT,
	input  wire logic              TX_SYS_SERIAL_IN,
	input  wire logic              TX_SYS_SIGNALING_IN,
	output tbi_pkg::tbi_word_s     TX_WORD_OUT,
	output logic                   TX_WORD_VALID_OUT,
	input  wire logic              RX_SYS_CLOCK_IN,
	output logic                   RX_SYS_CLOCK_OUT,
	output logic                   RX_SYS_CLOCK_OE_OUT,
	input  wire logic              RX_SYS_FRAME_PULSE_IN,
	output logic                   RX_SYS_FRAME_PULSE_OUT,
	output logic                   RX_SYS_FRAME_PULSE_OE_OUT,
	output logic                   RX_SYS_SERIAL_OUT,
	output logic                   RX_SYS_SIGNALING_OUT,
	output logic                   RX_SYS_DATA_OE_OUT,
	input  wire logic [7:0]        RX_DATA_IN,
	input  wire logic [7:0]        RX_SIG_IN,
	input  wire logic              RX_FBIT_IN,
	output logic                   RX_TAKE_OUT,
	output logic      [4:0]        RX_CHAN_OUT
);

	if (HALF_DIV < 16'h0001) begin : g_bad_div
		$error("HALF_DIV must be at least one");
	end

	tbi_pkg::tbi_state_s st_q;
	tbi_pkg::tbi_state_s st_d;
	logic [5:0]          pin;

	assign pin = {RX_SYS_FRAME_PULSE_IN, RX_SYS_CLOCK_IN,
		TX_SYS_SIGNALING_IN, TX_SYS_SERIAL_IN,
		TX_SYS_FRAME_PULSE_IN, TX_SYS_CLOCK_IN};

	// Which time slot and bit a frame position carries
	function automatic tbi_pkg::tbi_slot_s slot_of(logic e1,
		logic [1:0] map, logic [8:0] idx);
		tbi_pkg::tbi_slot_s s;
		logic [4:0]         ts;
		logic [8:0]         t;
		s = '0;
		ts = idx[7:3];
		t = idx - 9'h001;
		s.f = (idx == 9'h000);
		if (!e1) begin
			s.data = !s.f;
			s.chan = t[7:3];
			s.bit_no = t[2:0];
		end else begin
			s.bit_no = idx[2:0];
			case (map)
				2'b01: begin
					s.data = (ts >= 5'h01 && ts <= 5'h0f) ||
						(ts >= 5'h11 && ts <= 5'h19);
					s.chan = (ts <= 5'h0f) ? ts - 5'h01 : ts - 5'h02;
				end
				2'b10: begin
					s.data = (ts[1:0] != 2'b00);
					s.chan = ts - {2'b00, ts[4:2]} - 5'h01;
				end
				default: begin
					s.data = (ts >= 5'h01 && ts <= 5'h18);
					s.chan = ts - 5'h01;
				end
			endcase
		end
		return s;
	endfunction

	// Frame alignment of one direction: pulse arms, bit events count
	function automatic tbi_pkg::tbi_dir_s step(tbi_pkg::tbi_dir_s d,
		logic act, logic pev, logic double_rate_clock, logic edge_sel,
		logic [6:0] ch, logic [2:0] bo, logic e1);
		tbi_pkg::tbi_dir_s r;
		r = d;
		if (pev) begin
			r.ph = 1'b0;
			r.wt = {ch, 3'b000} + {7'b0000000, bo};
			r.run = 1'b0;
		end
		r.bev = act && (!double_rate_clock || r.ph == edge_sel);
		if (act) begin
			r.ph = !r.ph;
		end
		if (r.bev) begin
			if (!r.run) begin
				if (r.wt == 10'h000) begin
					r.run = 1'b1;
					r.idx = 9'h000;
				end else begin
					r.wt = r.wt - 10'h001;
				end
			end else if (r.idx == (e1 ? tbi_pkg::E1_LAST : tbi_pkg::T1_LAST)) begin
				r.idx = 9'h000;
			end else begin
				r.idx = r.idx + 9'h001;
			end
		end
		return r;
	endfunction

	function automatic logic [4:0] reg_slot(logic [11:0] addr);
		logic [4:0] k;
		k = 5'h1f;
		for (int i = 0; i < tbi_pkg::NREG; i++) begin
			if (addr[11:2] == tbi_pkg::REG_IX[i] && addr[1:0] == 2'b00) begin
				k = 5'(i);
			end
		end
		return k;
	endfunction

	always_comb begin
		logic               tslave;
		logic               rslave;
		logic               te1;
		logic               re1;
		logic               tck_o;
		logic               tck_n;
		logic               rck_o;
		logic               rck_n;
		logic               t_act;
		logic               t_fe;
		logic               r_act;
		logic               r_fe;
		logic               g_rise;
		logic               g_edge;
		logic               fs_on;
		logic [4:0]         k;
		tbi_pkg::tbi_slot_s ts;
		tbi_pkg::tbi_slot_s rs;
		tslave = 1'b0;
		rslave = 1'b0;
		te1 = 1'b0;
		re1 = 1'b0;
		tck_o = 1'b0;
		tck_n = 1'b0;
		rck_o = 1'b0;
		rck_n = 1'b0;
		t_act = 1'b0;
		t_fe = 1'b0;
		r_act = 1'b0;
		r_fe = 1'b0;
		g_rise = 1'b0;
		g_edge = 1'b0;
		fs_on = 1'b0;
		k = 5'h1f;
		ts = '0;
		rs = '0;
		st_d = st_q;
		st_d.tvalid = 1'b0;
		st_d.rtake = 1'b0;

		// Pin synchronisers: a level counts once stages two and three agree
		for (int i = 0; i < 6; i++) begin
			st_d.sy[i] = {st_q.sy[i][1:0], pin[i]};
			if (st_q.sy[i][1] == st_q.sy[i][2]) begin
				st_d.flt[i] = st_q.sy[i][2];
			end
		end

		// Internal bit clock for the clock master submodes
		if (st_q.div == HALF_DIV - 16'h0001) begin
			st_d.div = 16'h0000;
			st_d.gclk = !st_q.gclk;
			g_edge = 1'b1;
			if (!st_q.gclk) begin
				g_rise = 1'b1;
				if (st_q.gidx == tbi_pkg::T1_LAST) begin
					st_d.gidx = 9'h000;
					st_d.gfn = (st_q.gfn == tbi_pkg::MF_LAST) ? 5'h00 :
						st_q.gfn + 5'h01;
				end else begin
					st_d.gidx = st_q.gidx + 9'h001;
				end
			end
		end else begin
			st_d.div = st_q.div + 16'h0001;
		end

		// Transmit direction
		tslave = st_q.cfg[tbi_pkg::R_TXM][tbi_pkg::B_SUBMODE];
		te1 = tslave && st_q.cfg[tbi_pkg::R_TXM][tbi_pkg::B_MAP+:2] != 2'b00;
		tck_o = tslave ? st_q.flt[0] : st_q.gclk;
		tck_n = tslave ? st_d.flt[0] : st_d.gclk;
		t_act = (tck_o != tck_n) &&
			(tck_n == st_q.cfg[tbi_pkg::R_TCK][tbi_pkg::B_TDE]);
		t_fe = (tck_o != tck_n) &&
			(tck_n == st_q.cfg[tbi_pkg::R_TCK][tbi_pkg::B_TFE]);
		st_d.tx = step(st_q.tx, t_act,
			tslave ? (t_fe && st_q.flt[1]) : (g_rise && st_d.gidx == 9'h000),
			te1 && st_q.cfg[tbi_pkg::R_TCK][tbi_pkg::B_TCMS],
			st_q.cfg[tbi_pkg::R_TBO][tbi_pkg::B_EDGE],
			st_q.cfg[tbi_pkg::R_TCO][6:0],
			st_q.cfg[tbi_pkg::R_TBO][2:0], te1);
		ts = slot_of(te1, st_q.cfg[tbi_pkg::R_TXM][tbi_pkg::B_MAP+:2],
			st_d.tx.idx);
		if (st_d.tx.bev && st_d.tx.run) begin
			if (ts.f) begin
				st_d.tw.fbit = st_q.flt[2];
			end else if (ts.data) begin
				st_d.tx.sd = {st_q.tx.sd[6:0], st_q.flt[2]};
				st_d.tx.ss = {st_q.tx.ss[6:0], st_q.flt[3]};
				if (ts.bit_no == 3'h7) begin
					st_d.tw.chan = ts.chan;
					st_d.tw.data = st_d.tx.sd;
					st_d.tw.sig = st_d.tx.ss;
					st_d.tvalid = 1'b1;
				end
			end
		end
		st_d.t_oe = !tslave;
		st_d.tck_o = st_d.gclk;
		if (g_edge && st_d.gclk == st_q.cfg[tbi_pkg::R_TCK][tbi_pkg::B_TFE]) begin
			st_d.tfs_o = (st_d.gidx == 9'h000);
		end

		// Receive direction
		rslave = st_q.cfg[tbi_pkg::R_RXM][tbi_pkg::B_SUBMODE];
		re1 = rslave && st_q.cfg[tbi_pkg::R_RXM][tbi_pkg::B_MAP+:2] != 2'b00;
		rck_o = rslave ? st_q.flt[4] : st_q.gclk;
		rck_n = rslave ? st_d.flt[4] : st_d.gclk;
		r_act = (rck_o != rck_n) &&
			(rck_n == st_q.cfg[tbi_pkg::R_RXO][tbi_pkg::B_RDE]);
		r_fe = (rck_o != rck_n) &&
			(rck_n == st_q.cfg[tbi_pkg::R_RXO][tbi_pkg::B_RFE]);
		st_d.rx = step(st_q.rx, r_act,
			rslave ? (r_fe && (st_q.flt[5] ^
				st_q.cfg[tbi_pkg::R_RFP][tbi_pkg::B_INV])) :
				(g_rise && st_d.gidx == 9'h000),
			re1 && st_q.cfg[tbi_pkg::R_RXO][tbi_pkg::B_RCMS],
			st_q.cfg[tbi_pkg::R_RBO][tbi_pkg::B_EDGE],
			st_q.cfg[tbi_pkg::R_RCO][6:0],
			st_q.cfg[tbi_pkg::R_RBO][2:0], re1);
		rs = slot_of(re1, st_q.cfg[tbi_pkg::R_RXM][tbi_pkg::B_MAP+:2],
			st_d.rx.idx);
		if (st_d.rx.bev && st_d.rx.run) begin
			if (rs.f) begin
				st_d.rsd_o = RX_FBIT_IN;
				st_d.rsig_o = 1'b1;
			end else if (!rs.data) begin
				st_d.rsd_o = 1'b1;
				st_d.rsig_o = 1'b1;
			end else if (rs.bit_no == 3'h0) begin
				st_d.rsd_o = RX_DATA_IN[7];
				st_d.rsig_o = RX_SIG_IN[7];
				st_d.rx.sd = {RX_DATA_IN[6:0], 1'b0};
				st_d.rx.ss = {RX_SIG_IN[6:0], 1'b0};
				st_d.rtake = 1'b1;
				st_d.rchan = rs.chan;
			end else begin
				st_d.rsd_o = st_q.rx.sd[7];
				st_d.rsig_o = st_q.rx.ss[7];
				st_d.rx.sd = {st_q.rx.sd[6:0], 1'b0};
				st_d.rx.ss = {st_q.rx.ss[6:0], 1'b0};
			end
		end
		st_d.rd_oe = !st_q.cfg[tbi_pkg::R_RXO][tbi_pkg::B_TRI];
		st_d.r_oe = !rslave;
		st_d.rck_o = st_d.gclk && !(st_q.cfg[tbi_pkg::R_RXO][tbi_pkg::B_GAP] &&
			st_d.gidx == 9'h000);
		if (SF_FORMAT_IN) begin
			case ({st_q.cfg[tbi_pkg::R_RFP][tbi_pkg::B_FRAME_PULSE_MULTIFRAME],
				st_q.cfg[tbi_pkg::R_RFP][tbi_pkg::B_ALT]})
				2'b01: fs_on = !st_d.gfn[0];
				2'b10: fs_on = (st_d.gfn == 5'h00 || st_d.gfn == tbi_pkg::SF_LEN);
				2'b11: fs_on = (st_d.gfn == 5'h00);
				default: fs_on = 1'b1;
			endcase
		end else begin
			fs_on = !st_q.cfg[tbi_pkg::R_RFP][tbi_pkg::B_FRAME_PULSE_MULTIFRAME] ||
				st_d.gfn == 5'h00;
		end
		if (g_edge && st_d.gclk == st_q.cfg[tbi_pkg::R_RXO][tbi_pkg::B_RFE]) begin
			st_d.rfs_o = (fs_on && st_d.gidx == 9'h000) ^
				st_q.cfg[tbi_pkg::R_RFP][tbi_pkg::B_INV];
		end

		// APB slave: one wait state, write lands at the completing edge
		k = reg_slot(PADDR_IN);
		st_d.rdy = 1'b0;
		if (PSEL_IN && PENABLE_IN && !st_q.rdy) begin
			st_d.rdy = 1'b1;
			st_d.err = (k == 5'h1f);
			if (k == 5'h1f) begin
				st_d.rdata = 8'h00;
			end else if (k == 5'(tbi_pkg::R_STS)) begin
				st_d.rdata = {st_q.rx.run, st_q.tx.run, st_q.tx.idx[8:3]};
			end else begin
				st_d.rdata = st_q.cfg[k[3:0]];
			end
		end
		if (PSEL_IN && PENABLE_IN && st_q.rdy && PWRITE_IN &&
			k < 5'(tbi_pkg::R_STS)) begin
			st_d.cfg[k[3:0]] = PWDATA_IN[7:0] & tbi_pkg::WR_MASK[k[3:0]];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			st_q <= '0;
			st_q.cfg <= tbi_pkg::RST_VAL;
		end else begin
			st_q <= st_d;
		end
	end

	assign PRDATA_OUT = {24'h00_0000, st_q.rdata};
	assign PREADY_OUT = st_q.rdy;
	assign PSLVERR_OUT = st_q.err;
	assign TX_SYS_CLOCK_OUT = st_q.tck_o;
	assign TX_SYS_CLOCK_OE_OUT = st_q.t_oe;
	assign TX_SYS_FRAME_PULSE_OUT = st_q.tfs_o;
	assign TX_SYS_FRAME_PULSE_OE_OUT = st_q.t_oe;
	assign TX_WORD_OUT = st_q.tw;
	assign TX_WORD_VALID_OUT = st_q.tvalid;
	assign RX_SYS_CLOCK_OUT = st_q.rck_o;
	assign RX_SYS_CLOCK_OE_OUT = st_q.r_oe;
	assign RX_SYS_FRAME_PULSE_OUT = st_q.rfs_o;
	assign RX_SYS_FRAME_PULSE_OE_OUT = st_q.r_oe;
	assign RX_SYS_SERIAL_OUT = st_q.rsd_o;
	assign RX_SYS_SIGNALING_OUT = st_q.rsig_o;
	assign RX_SYS_DATA_OE_OUT = st_q.rd_oe;
	assign RX_TAKE_OUT = st_q.rtake;
	assign RX_CHAN_OUT = st_q.rchan;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	a_tx_master_drive: assert property (
		!st_q.cfg[tbi_pkg::R_TXM][0] |=> TX_SYS_CLOCK_OE_OUT)
		else $error("Transmit master does not drive its clock");
	a_rx_slave_float: assert property (
		st_q.cfg[tbi_pkg::R_RXM][0] |=> !RX_SYS_CLOCK_OE_OUT)
		else $error("Receive slave drives the clock pin");
	a_rx_data_float: assert property (
		st_q.cfg[tbi_pkg::R_RXO][0] |=> !RX_SYS_DATA_OE_OUT)
		else $error("Receive data not floated");
	a_frame_start_wait: assert property (
		$rose(st_q.rx.run) |-> $past(st_q.rx.wt) == 10'h000)
		else $error("Receive frame started before offset elapsed");
	a_tx_slot_select: assert property (
		st_q.tx.bev && st_q.cfg[tbi_pkg::R_TCK][2] &&
		st_q.cfg[tbi_pkg::R_TXM][0] && st_q.cfg[tbi_pkg::R_TXM][2:1] != 2'b00
		|-> $past(st_q.tx.ph) == st_q.cfg[tbi_pkg::R_TBO][3] ||
		$past(st_q.tx.run) != st_q.tx.run || st_q.tx.wt != $past(st_q.tx.wt))
		else $error("Transmit sample on wrong double rate edge");
	a_rx_gap_clock: assert property (
		st_q.cfg[tbi_pkg::R_RXO][4] && st_q.gidx == 9'h000 &&
		$stable(st_q.cfg) |-> !RX_SYS_CLOCK_OUT)
		else $error("Receive clock not gapped in F-bit");
	a_rx_bit_spacing: assert property (
		st_q.rx.bev && !st_q.cfg[tbi_pkg::R_RXM][0] |=> !st_q.rx.bev [*2])
		else $error("Receive bit events too close");
	a_apb_one_wait: assert property (
		PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT ##1 !PREADY_OUT)
		else $error("APB ready not a single cycle after one wait");

endmodule

// >>> verification/tbi_partner.sv
// Model of the system-side framer that drives the transmit pins as slave.
// Assumes the block samples these pins with its own unrelated clock.
`timescale 1ns/1ps
module tbi_partner (
	output logic clk_out,
	output logic fp_out,
	output logic sd_out,
	output logic sig_out
);
	event f_done;

	initial begin
		clk_out = 1'b0;
		fp_out  = 1'b0;
		sd_out  = 1'b0;
		sig_out = 1'b0;
	end

	// Pulse on the first bit, lead filler bits, F-bit, then two channels MSB first
	task automatic send(input int lead, input logic f,
			input logic [15:0] d, input logic [15:0] s);
		logic [16:0] dv;
		logic [16:0] sv;
		dv = {f, d};
		sv = {f, s};
		#37;
		for (int i = 0; i <= lead + 16; i++) begin
			fp_out = (i == 0);
			if (i < lead) begin
				sd_out  = ~sd_out;
				sig_out = ~sig_out;
			end else begin
				sd_out  = dv[16 - (i - lead)];
				sig_out = sv[16 - (i - lead)];
			end
			// Data held across both edges of its bit
			#200 clk_out = 1'b1;
			#400 clk_out = 1'b0;
			#200;
			if (i == lead) -> f_done;
		end
		// Clock stands still; released lines show the inverse
		fp_out  = 1'b0;
		sd_out  = ~sd_out;
		sig_out = ~sig_out;
	endtask
endmodule

// >>> verification/tbi_backplane_bench.sv
// Self-checking bench of the backplane interface: APB registers,
// transmit slave capture, master timing and receive pulse generation.
// Assumes the design's package is compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	fails++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tbi_backplane_bench;
	localparam logic [15:0] HALF = 16'h0004;
	logic clk, rst, psel, pen, pwr, sf;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, tck, tfs, tsd, tsig, tv;
	logic tck_o, tck_oe, tfs_o, tfs_oe, rck_o, rck_oe, rfs_o, rfs_oe;
	logic rsd_o, rsig_o, rd_oe, rtake;
	logic [4:0] rchan;
	tbi_pkg::tbi_word_s tw;
	int fails, samples_checked;
	logic [9:0] ix [8] = '{tbi_pkg::IX_TX_MODE, tbi_pkg::IX_TX_CHOFF,
		tbi_pkg::IX_TX_BITOFF, tbi_pkg::IX_RX_OPT, tbi_pkg::IX_RX_MODE,
		tbi_pkg::IX_RX_FP, tbi_pkg::IX_RX_CHOFF, tbi_pkg::IX_RX_BITOFF};
	logic [7:0] rv [8] = '{8'h01, 8'h00, 8'h00, 8'h0d, 8'h01, 8'h00,
		8'h00, 8'h00};
	logic [7:0] mk [8] = '{8'h07, 8'h7f, 8'h0f, 8'h1f, 8'h07, 8'h13,
		8'h7f, 8'h0f};

	tbi_backplane #(.HALF_DIV(HALF)) tbi_backplane_inst (
		.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .SF_FORMAT_IN(sf),
		.TX_SYS_CLOCK_IN(tck), .TX_SYS_CLOCK_OUT(tck_o),
		.TX_SYS_CLOCK_OE_OUT(tck_oe), .TX_SYS_FRAME_PULSE_IN(tfs),
		.TX_SYS_FRAME_PULSE_OUT(tfs_o),
		.TX_SYS_FRAME_PULSE_OE_OUT(tfs_oe), .TX_SYS_SERIAL_IN(tsd),
		.TX_SYS_SIGNALING_IN(tsig), .TX_WORD_OUT(tw),
		.TX_WORD_VALID_OUT(tv), .RX_SYS_CLOCK_IN(1'b0),
		.RX_SYS_CLOCK_OUT(rck_o), .RX_SYS_CLOCK_OE_OUT(rck_oe),
		.RX_SYS_FRAME_PULSE_IN(1'b0), .RX_SYS_FRAME_PULSE_OUT(rfs_o),
		.RX_SYS_FRAME_PULSE_OE_OUT(rfs_oe), .RX_SYS_SERIAL_OUT(rsd_o),
		.RX_SYS_SIGNALING_OUT(rsig_o), .RX_SYS_DATA_OE_OUT(rd_oe),
		.RX_DATA_IN(8'ha5), .RX_SIG_IN(8'h3c), .RX_FBIT_IN(1'b1),
		.RX_TAKE_OUT(rtake), .RX_CHAN_OUT(rchan));

	tbi_partner tbi_partner_inst (.clk_out(tck), .fp_out(tfs),
		.sd_out(tsd), .sig_out(tsig));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic apb(input logic wr, input logic [9:0] a,
			input logic [7:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= wr;
		paddr  <= {a, 2'b00};
		pwdata <= {24'h0000_00, wd};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fails++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task automatic wreg(input logic [9:0] a, input logic [7:0] wd);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, wd, rd, er);
	endtask

	task automatic test_regs();
		logic [31:0] rd;
		logic er;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, ix[i], 8'h00, rd, er);
			`CHK(rd, {24'h0000_00, rv[i]})
			`CHK(er, 1'b0)
			wreg(ix[i], 8'hff);
			apb(1'b0, ix[i], 8'h00, rd, er);
			`CHK(rd, {24'h0000_00, mk[i]})
			wreg(ix[i], rv[i]);
		end
		apb(1'b1, 10'h010, 8'hff, rd, er);
		`CHK(er, 1'b1)
		apb(1'b0, 10'h010, 8'h00, rd, er);
		`CHK({er, rd}, {1'b1, 32'h0000_0000})
		$display("test regs done");
	endtask

	task automatic get_word(output tbi_pkg::tbi_word_s w);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tv !== 1'b1 && n < 2000);
		if (tv !== 1'b1) fails++;
		w = tw;
	endtask

	task automatic tx_case(input logic [6:0] co, input logic [2:0] bo,
			input logic [15:0] d, input logic [15:0] s);
		tbi_pkg::tbi_word_s w0, w1;
		wreg(tbi_pkg::IX_TX_CHOFF, {1'b0, co});
		wreg(tbi_pkg::IX_TX_BITOFF, {5'h00, bo});
		fork
			tbi_partner_inst.send(int'(co) * 8 + int'(bo), 1'b1, d, s);
			begin
				@(tbi_partner_inst.f_done);
				get_word(w0);
				get_word(w1);
			end
		join
		`CHK({w0.chan, w0.data}, {5'h00, d[15:8]})
		`CHK({w1.chan, w1.data}, {5'h01, d[7:0]})
		`CHK({w0.sig, w1.sig}, s)
		$display("test tx offset done");
	endtask

	task automatic test_master();
		int tog;
		int m;
		logic p;
		`CHK(rd_oe, 1'b0)
		wreg(tbi_pkg::IX_RX_OPT, 8'h0c);
		wreg(tbi_pkg::IX_RX_MODE, 8'h00);
		wreg(tbi_pkg::IX_TX_MODE, 8'h00);
		repeat (4) @(negedge clk);
		`CHK(rd_oe, 1'b1)
		`CHK({rck_oe, rfs_oe}, 2'b11)
		`CHK({tck_oe, tfs_oe}, 2'b11)
		tog = 0;
		p = tck_o;
		repeat (100) begin
			@(negedge clk);
			if (tck_o !== p) tog++;
			p = tck_o;
		end
		`CHK(tog >= 24 && tog <= 26, 1'b1)
		// Receive master plays channel 0 out of the user byte, MSB first
		m = 0;
		do begin
			@(negedge clk);
			m++;
		end while (!(rtake === 1'b1 && rchan === 5'h00) && m < 2000);
		`CHK({rtake, rchan}, 6'h20)
		`CHK({rsd_o, rsig_o}, 2'b10)
		wreg(tbi_pkg::IX_TX_MODE, 8'h01);
		repeat (4) @(negedge clk);
		`CHK({tck_oe, tfs_oe}, 2'b00)
		$display("test master done");
	endtask

	task automatic rx_pulse(input int fr, input logic s, input logic cm,
			input logic alt, input logic inv, input logic gap);
		int n, ncyc, nrise, nact;
		logic a, ap, pc;
		@(posedge clk);
		sf <= s;
		wreg(tbi_pkg::IX_RX_FP, {3'b000, inv, 2'b00, cm, alt});
		wreg(tbi_pkg::IX_RX_OPT, {3'b000, gap, 4'hc});
		repeat (20) @(negedge clk);
		ap = 1'b1;
		for (n = 0; n < 40000; n++) begin
			@(negedge clk);
			a = rfs_o ^ inv;
			if (a === 1'b1 && ap === 1'b0) break;
			ap = a;
		end
		ncyc = 0;
		nrise = 0;
		nact = 0;
		pc = rck_o;
		ap = 1'b1;
		for (n = 0; n < 40000; n++) begin
			@(negedge clk);
			ncyc++;
			a = rfs_o ^ inv;
			if (rck_o === 1'b1 && pc === 1'b0) nrise++;
			pc = rck_o;
			if (a === 1'b1) nact++;
			if (a === 1'b1 && ap === 1'b0) break;
			ap = a;
		end
		`CHK(ncyc, fr * 193 * 2 * int'(HALF))
		`CHK(nrise, fr * (193 - int'(gap)))
		`CHK(nact < 100, 1'b1)
		$display("test rx pulse done");
	endtask

	task automatic test_done();
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		sf = 1'b0;
		fails = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		test_regs();
		wreg(tbi_pkg::IX_TX_CLKOPT, 8'h18);
		tx_case(7'h00, 3'h0, 16'ha53c, 16'h96e1);
		tx_case(7'h17, 3'h7, 16'h1ff0, 16'h8421);
		test_master();
		rx_pulse(1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		rx_pulse(2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		rx_pulse(12, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		rx_pulse(1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		test_done();
	end
endmodule
